//--- shared/mc36_pkg.sv
/*
  Shared constants, types and coding functions of the byte symbol codec.
  Assumes a single clock domain and a 32-bit register bus with word-aligned byte addressing.
*/
package mc36_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_DATA_LOW = 8'hC2;
  localparam logic [7:0] IDX_DATA_MIDDLE = 8'hC3;
  localparam logic [7:0] IDX_DATA_HIGH = 8'hC4;
  localparam logic [7:0] IDX_CONTROL = 8'hC5;
  localparam int ADDR_W = 12;

  // Control field positions
  localparam int CTL_READY = 7;
  localparam int CTL_ERROR = 6;
  localparam int CTL_ENC = 5;
  localparam int CTL_DEC = 4;
  localparam int CTL_DMA = 2;
  localparam int CTL_ENDIAN = 1;
  localparam int CTL_MODE = 0;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'h37;
  localparam logic [23:0] DATA_RESET = 24'h000000;
  localparam logic [7:0] MAN_ERR_BYTE = 8'hFF;

  typedef enum logic [1:0] {
    MC36_IDLE,
    MC36_FETCH,
    MC36_CALC,
    MC36_PUSH
  } mc36_state_e;

  function automatic logic [7:0] man_enc(input logic [3:0] nib);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      r[2*i+1] = ~nib[i];
      r[2*i] = nib[i];
    end
    return r;
  endfunction : man_enc

  // Returns {error, nibble}
  function automatic logic [4:0] man_dec(input logic [7:0] b);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 4; i++)
    begin
      r[i] = b[2*i];
      if (b[2*i+1] == b[2*i])
        r[4] = 1'b1;
    end
    return r;
  endfunction : man_dec

  function automatic logic [5:0] s36_enc(input logic [3:0] nib);
    case (nib)
      4'h0: return 6'h16;
      4'h1: return 6'h0D;
      4'h2: return 6'h0E;
      4'h3: return 6'h0B;
      4'h4: return 6'h1C;
      4'h5: return 6'h19;
      4'h6: return 6'h1A;
      4'h7: return 6'h13;
      4'h8: return 6'h2C;
      4'h9: return 6'h25;
      4'hA: return 6'h26;
      4'hB: return 6'h23;
      4'hC: return 6'h34;
      4'hD: return 6'h31;
      4'hE: return 6'h32;
      default: return 6'h29;
    endcase
  endfunction : s36_enc

  // Searching the encode table keeps decode an exact inverse; returns {error, nibble}
  function automatic logic [4:0] s36_dec(input logic [5:0] sym);
    logic [4:0] r;
    r = 5'h10;
    for (int k = 0; k < 16; k++)
    begin
      if (s36_enc(4'(k)) == sym)
        r = {1'b0, 4'(k)};
    end
    return r;
  endfunction : s36_dec

  // Byte counts per unit, minus one
  function automatic logic [1:0] in_last(input logic mode, input logic code_go);
    return mode ? (code_go ? 2'd1 : 2'd2) : (code_go ? 2'd0 : 2'd1);
  endfunction : in_last

  function automatic logic [1:0] out_last(input logic mode, input logic code_go);
    return mode ? (code_go ? 2'd2 : 2'd1) : (code_go ? 2'd1 : 2'd0);
  endfunction : out_last

endpackage : mc36_pkg

//--- shared/mc36_if.sv
/*
  Link between the codec control logic and its coding datapath.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface mc36_if;
  logic go;
  logic encode;
  logic mode;
  logic [23:0] din;
  logic done;
  logic err;
  logic [23:0] dout;

  modport ctl (output go, output encode, output mode, output din,
    input done, input err, input dout);
  modport core (input go, input encode, input mode, input din,
    output done, output err, output dout);
endinterface : mc36_if

//--- hdl/mc36_core.sv
/*
  Coding datapath: one unit of Manchester or three-out-of-six encode or decode.
  Assumes go is a one-cycle pulse and din is stable while go is high.
*/
`timescale 1ns/1ps
module mc36_core (
  input wire logic clk_in,
  input wire logic rst_in,
  mc36_if.core cif
);

  typedef struct packed {
    logic done;
    logic err;
    logic [23:0] dout;
  } mc36_core_s;

  mc36_core_s q;
  mc36_core_s d;

  always_comb
  begin
    logic [4:0] hi;
    logic [4:0] lo;
    logic [4:0] n3;
    logic [4:0] n2;
    logic [4:0] n1;
    logic [4:0] n0;
    hi = mc36_pkg::man_dec(cif.din[15:8]);
    lo = mc36_pkg::man_dec(cif.din[7:0]);
    n3 = mc36_pkg::s36_dec(cif.din[23:18]);
    n2 = mc36_pkg::s36_dec(cif.din[17:12]);
    n1 = mc36_pkg::s36_dec(cif.din[11:6]);
    n0 = mc36_pkg::s36_dec(cif.din[5:0]);
    d = q;
    d.done = cif.go;
    if (cif.go)
    begin
      d.err = 1'b0;
      case ({cif.mode, cif.encode})
        2'b01:
        begin
          d.dout = {8'h00, mc36_pkg::man_enc(cif.din[7:4]), mc36_pkg::man_enc(cif.din[3:0])};
        end
        2'b00:
        begin
          d.err = hi[4] | lo[4];
          d.dout = {16'h0000, hi[3:0], lo[3:0]};
          if (d.err)
            d.dout = {16'h0000, mc36_pkg::MAN_ERR_BYTE};
        end
        2'b11:
        begin
          d.dout = {mc36_pkg::s36_enc(cif.din[15:12]), mc36_pkg::s36_enc(cif.din[11:8]),
            mc36_pkg::s36_enc(cif.din[7:4]), mc36_pkg::s36_enc(cif.din[3:0])};
        end
        default:
        begin
          d.err = n3[4] | n2[4] | n1[4] | n0[4];
          d.dout = {8'h00, n3[3:0], n2[3:0], n1[3:0], n0[3:0]};
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      q <= '0;
    else
      q <= d;
  end

  assign cif.done = q.done;
  assign cif.err = q.err;
  assign cif.dout = q.dout;

endmodule : mc36_core

//--- hdl/mc36_codec.sv
/*
  Manchester and three-out-of-six byte codec with APB registers and DMA
  request/acknowledge byte streams.
  Assumes an APB master, and a DMA engine that pulses ack for one cycle per
  byte while the matching request is high, with input data valid during ack.
*/
// Functional notes
// - Manchester decode of middle and low bytes
// - Ready after decode; invalid gives all ones, error
// - Pair 01 is one, 10 is zero
// - Each nibble becomes a six-bit symbol
// - Encode two bytes into three registers
// - Fixed sixteen-entry symbol table
// - Decode three bytes; bad symbol sets error
// - Symbol decode exactly inverts encode
// - Operation values 10,11,20,21 without DMA
// - Only software clears ready and error
// - Interrupt output follows decode error
// - DMA decode continues after error, error sticky
// - Request input and output bytes for DMA
// - Operation values 16,17,26,27 with DMA
// - Data right-justified; high unused for Manchester
// - Start bits clear after launch
// - Mode zero Manchester, one three-of-six
`timescale 1ns/1ps
module mc36_codec (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [mc36_pkg::ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic dma_in_req_out,
  input wire logic dma_in_ack_in,
  input wire logic [7:0] dma_in_data_in,
  output logic dma_out_req_out,
  input wire logic dma_out_ack_in,
  output logic [7:0] dma_out_data_out,
  output logic err_irq_out
);

  typedef struct packed {
    mc36_pkg::mc36_state_e st;
    logic [7:0] ctrl;
    logic [23:0] data;
    logic [1:0] cnt;
    logic go;
    logic op_enc;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic in_req;
    logic out_req;
    logic [7:0] out_byte;
    logic irq;
  } mc36_codec_s;

  mc36_codec_s q;
  mc36_codec_s d;

  mc36_if cif ();

  mc36_core u_core (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .cif(cif)
  );

  assign cif.go = q.go;
  assign cif.encode = q.op_enc;
  assign cif.mode = q.ctrl[mc36_pkg::CTL_MODE];
  assign cif.din = q.data;

  // Decodes a byte address into a register index; low bits must be zero
  function automatic logic [2:0] reg_sel(input logic [mc36_pkg::ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'd0;
    if (a[1:0] == 2'b00 && a[mc36_pkg::ADDR_W-1:10] == '0)
    begin
      case (a[9:2])
        mc36_pkg::IDX_DATA_LOW: r = 3'd1;
        mc36_pkg::IDX_DATA_MIDDLE: r = 3'd2;
        mc36_pkg::IDX_DATA_HIGH: r = 3'd3;
        mc36_pkg::IDX_CONTROL: r = 3'd4;
        default: r = 3'd0;
      endcase
    end
    return r;
  endfunction : reg_sel

  // Byte position in the data word for stream slot cnt of a unit of last+1 bytes
  function automatic logic [1:0] slot(input logic big, input logic [1:0] last,
    input logic [1:0] cnt);
    return big ? 2'(last - cnt) : cnt;
  endfunction : slot

  function automatic logic [7:0] pick(input logic [23:0] w, input logic [1:0] i);
    case (i)
      2'd0: return w[7:0];
      2'd1: return w[15:8];
      default: return w[23:16];
    endcase
  endfunction : pick

  always_comb
  begin
    logic [2:0] sel;
    logic setup;
    logic access;
    logic mode;
    logic big;
    logic [1:0] ilast;
    logic [1:0] olast;
    logic [1:0] pos;
    sel = reg_sel(paddr_in);
    setup = psel_in & ~penable_in;
    access = psel_in & penable_in & q.pready;
    mode = q.ctrl[mc36_pkg::CTL_MODE];
    big = q.ctrl[mc36_pkg::CTL_ENDIAN];
    ilast = mc36_pkg::in_last(mode, q.op_enc);
    olast = mc36_pkg::out_last(mode, q.op_enc);
    pos = slot(big, ilast, q.cnt);
    d = q;
    d.go = 1'b0;

    // APB slave: read data is captured in setup, answer given in the first access cycle
    d.pready = setup;
    // Error response stands only beside its pready pulse
    d.pslverr = 1'b0;
    if (setup)
    begin
      d.pslverr = (sel == 3'd0);
      case (sel)
        3'd1: d.prdata = {24'h000000, q.data[7:0]};
        3'd2: d.prdata = {24'h000000, q.data[15:8]};
        3'd3: d.prdata = {24'h000000, q.data[23:16]};
        3'd4: d.prdata = {24'h000000, q.ctrl};
        default: d.prdata = 32'h00000000;
      endcase
    end
    if (access && pwrite_in)
    begin
      case (sel)
        3'd1: d.data[7:0] = pwdata_in[7:0];
        3'd2: d.data[15:8] = pwdata_in[7:0];
        3'd3: d.data[23:16] = pwdata_in[7:0];
        3'd4:
        begin
          // Flags can only be cleared by writing zero, never set by software
          d.ctrl = pwdata_in[7:0] & mc36_pkg::CTL_WMASK;
          d.ctrl[mc36_pkg::CTL_READY] = q.ctrl[mc36_pkg::CTL_READY]
            & pwdata_in[mc36_pkg::CTL_READY];
          d.ctrl[mc36_pkg::CTL_ERROR] = q.ctrl[mc36_pkg::CTL_ERROR]
            & pwdata_in[mc36_pkg::CTL_ERROR];
        end
        default:
        begin
        end
      endcase
    end

    case (q.st)
      mc36_pkg::MC36_IDLE:
      begin
        if (q.ctrl[mc36_pkg::CTL_ENC] | q.ctrl[mc36_pkg::CTL_DEC])
        begin
          d.op_enc = q.ctrl[mc36_pkg::CTL_ENC];
          d.ctrl[mc36_pkg::CTL_ENC] = 1'b0;
          d.ctrl[mc36_pkg::CTL_DEC] = 1'b0;
          d.cnt = 2'd0;
          if (q.ctrl[mc36_pkg::CTL_DMA])
          begin
            d.st = mc36_pkg::MC36_FETCH;
            d.data = mc36_pkg::DATA_RESET;
          end
          else
          begin
            d.st = mc36_pkg::MC36_CALC;
            d.go = 1'b1;
          end
        end
      end
      mc36_pkg::MC36_FETCH:
      begin
        if (dma_in_ack_in)
        begin
          case (pos)
            2'd0: d.data[7:0] = dma_in_data_in;
            2'd1: d.data[15:8] = dma_in_data_in;
            default: d.data[23:16] = dma_in_data_in;
          endcase
          d.cnt = 2'(q.cnt + 2'd1);
          if (q.cnt == ilast)
          begin
            d.st = mc36_pkg::MC36_CALC;
            d.go = 1'b1;
          end
        end
      end
      mc36_pkg::MC36_CALC:
      begin
        if (cif.done)
        begin
          d.data = cif.dout;
          d.ctrl[mc36_pkg::CTL_READY] = 1'b1;
          if (cif.err)
            d.ctrl[mc36_pkg::CTL_ERROR] = 1'b1;
          d.cnt = 2'd0;
          if (q.ctrl[mc36_pkg::CTL_DMA])
            d.st = mc36_pkg::MC36_PUSH;
          else
            d.st = mc36_pkg::MC36_IDLE;
        end
      end
      mc36_pkg::MC36_PUSH:
      begin
        if (dma_out_ack_in)
        begin
          d.cnt = 2'(q.cnt + 2'd1);
          if (q.cnt == olast)
          begin
            // Streaming carries on until software drops the DMA enable
            d.cnt = 2'd0;
            if (q.ctrl[mc36_pkg::CTL_DMA])
            begin
              d.st = mc36_pkg::MC36_FETCH;
              d.data = mc36_pkg::DATA_RESET;
            end
            else
              d.st = mc36_pkg::MC36_IDLE;
          end
        end
      end
      default:
      begin
        d.st = mc36_pkg::MC36_IDLE;
      end
    endcase

    // A cleared DMA enable aborts a stream that waits on the engine
    if (!d.ctrl[mc36_pkg::CTL_DMA] &&
      (d.st == mc36_pkg::MC36_FETCH || d.st == mc36_pkg::MC36_PUSH))
      d.st = mc36_pkg::MC36_IDLE;

    d.in_req = (d.st == mc36_pkg::MC36_FETCH);
    d.out_req = (d.st == mc36_pkg::MC36_PUSH);
    d.out_byte = pick(d.data, slot(d.ctrl[mc36_pkg::CTL_ENDIAN],
      mc36_pkg::out_last(d.ctrl[mc36_pkg::CTL_MODE], d.op_enc), d.cnt));
    d.irq = d.ctrl[mc36_pkg::CTL_ERROR];
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '0;
      q.st <= mc36_pkg::MC36_IDLE;
      q.ctrl <= mc36_pkg::CTL_RESET;
      q.data <= mc36_pkg::DATA_RESET;
    end
    else
      q <= d;
  end

  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign dma_in_req_out = q.in_req;
  assign dma_out_req_out = q.out_req;
  assign dma_out_data_out = q.out_byte;
  assign err_irq_out = q.irq;

endmodule : mc36_codec

//--- sim/mc36_codec_sva.sv
/* Assertions on the codec bus and stream ports.
   Assumes one clock and an active-high reset; bound to every codec. */
`timescale 1ns/1ps
module mc36_codec_sva (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [mc36_pkg::ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic dma_in_req_out,
  input wire logic dma_in_ack_in,
  input wire logic dma_out_req_out,
  input wire logic dma_out_ack_in,
  input wire logic [7:0] dma_out_data_out,
  input wire logic err_irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic wr;
  assign wr = psel_in && penable_in && pwrite_in;
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_last_in;
    dma_in_ack_in && dma_in_req_out && !wr ##1 !dma_in_req_out && !wr ##1 !wr;
  endsequence
  property p_rdy; s_setup |=> pready_out; endproperty
  property p_pulse; pready_out |=> !pready_out; endproperty
  property p_slv; pslverr_out |-> pready_out; endproperty
  property p_rhi; pready_out |-> prdata_out[31:8] == 24'h000000; endproperty
  property p_irq; $fell(err_irq_out) |-> $past(wr && paddr_in == 12'h314 && !pwdata_in[6], 1);
  endproperty
  property p_inh; dma_in_req_out && !dma_in_ack_in && !wr |=> dma_in_req_out; endproperty
  property p_outh;
    dma_out_req_out && !dma_out_ack_in && !wr |=> dma_out_req_out && $stable(dma_out_data_out);
  endproperty
  property p_out; s_last_in |-> ##[1:4] dma_out_req_out; endproperty
  property p_excl; !(dma_in_req_out && dma_out_req_out); endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  a_pulse: assert property (p_pulse) else $error("pready too long");
  a_slv: assert property (p_slv) else $error("pslverr without pready");
  a_rhi: assert property (p_rhi) else $error("read data upper bits set");
  a_irq: assert property (p_irq) else $error("error irq fell uncleared");
  a_inh: assert property (p_inh) else $error("input request dropped");
  a_outh: assert property (p_outh) else $error("output byte not held");
  a_out: assert property (p_out) else $error("no output after input");
  a_excl: assert property (p_excl) else $error("both requests high");
endmodule : mc36_codec_sva
bind mc36_codec mc36_codec_sva mc36_codec_sva_i (.mclk_in, .rst_in, .paddr_in, .psel_in,
  .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .dma_in_req_out, .dma_in_ack_in, .dma_out_req_out, .dma_out_ack_in, .dma_out_data_out,
  .err_irq_out);

//--- sim/mc36_dma_model.sv
/* Two-channel DMA model: feeds input bytes, collects output bytes.
   Assumes request levels from the codec; stalls dly_in cycles per byte. */
`timescale 1ns/1ps
module mc36_dma_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [3:0] dly_in,
  input wire logic [47:0] src_in,
  input wire logic in_req_in,
  output logic in_ack_out,
  output logic [7:0] in_data_out,
  input wire logic out_req_in,
  output logic out_ack_out,
  input wire logic [7:0] out_data_in,
  output logic [47:0] sink_out,
  output logic [3:0] n_out
);
  logic [2:0] idx;
  logic [3:0] wi, wo;
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {in_ack_out, out_ack_out, in_data_out, idx, wi, wo, sink_out, n_out} <= '0;
    end
    else
    begin
      in_ack_out <= 1'b0;
      out_ack_out <= 1'b0;
      // Data off the ack cycle changes so a stale byte is never taken
      in_data_out <= ~in_data_out;
      if (!go_in)
        {idx, wi, wo, sink_out, n_out} <= '0;
      else
      begin
        // Channel 0 feeds the codec, channel 1 drains it, first byte most significant
        if (in_req_in && !in_ack_out)
        begin
          wi <= (wi == dly_in) ? 4'h0 : wi + 4'h1;
          if (wi == dly_in)
          begin
            in_ack_out <= 1'b1;
            in_data_out <= (idx < 3'h6) ? src_in[47-8*idx -: 8] : 8'h00;
            idx <= idx + 3'h1;
          end
        end
        if (out_req_in && !out_ack_out)
        begin
          wo <= (wo == dly_in) ? 4'h0 : wo + 4'h1;
          if (wo == dly_in)
          begin
            out_ack_out <= 1'b1;
            sink_out <= {sink_out[39:0], out_data_in};
            n_out <= n_out + 4'h1;
          end
        end
      end
    end
  end
endmodule : mc36_dma_model

//--- sim/test_mc36_codec.sv
/* Self-checking bench of the codec: register operations and DMA streams.
   Assumes the DMA model in sim/ and the shared package. */
`timescale 1ns/1ps
module test_mc36_codec;
  localparam logic [11:0] AL = {2'b00, mc36_pkg::IDX_DATA_LOW, 2'b00};
  localparam logic [11:0] AM = {2'b00, mc36_pkg::IDX_DATA_MIDDLE, 2'b00};
  localparam logic [11:0] AH = {2'b00, mc36_pkg::IDX_DATA_HIGH, 2'b00};
  localparam logic [11:0] AC = {2'b00, mc36_pkg::IDX_CONTROL, 2'b00};
  logic [5:0] sym [16] = '{6'h16, 6'h0D, 6'h0E, 6'h0B, 6'h1C, 6'h19, 6'h1A, 6'h13,
    6'h2C, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};
  logic mclk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd;
  logic pready_out, pslverr_out, iq, ia, oq, oa, err_irq_out, er, go = 1'b0;
  logic [7:0] idat, odat;
  logic [3:0] dly = 4'h0, n_got;
  logic [47:0] src = 48'h000000000000, sink;
  int n_errors = 0, total_checks = 0;
  mc36_codec mc36_codec_i (.mclk_in, .rst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .dma_in_req_out(iq),
    .dma_in_ack_in(ia), .dma_in_data_in(idat), .dma_out_req_out(oq), .dma_out_ack_in(oa),
    .dma_out_data_out(odat), .err_irq_out);
  mc36_dma_model mc36_dma_model_i (.mclk_in, .rst_in, .go_in(go), .dly_in(dly), .src_in(src),
    .in_req_in(iq), .in_ack_out(ia), .in_data_out(idat), .out_req_in(oq), .out_ack_out(oa),
    .out_data_in(odat), .sink_out(sink), .n_out(n_got));
  initial forever #25 mclk_in = ~mclk_in;
  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string s, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk_in);
    {psel_in, penable_in, pwrite_in, paddr_in} <= {1'b1, 1'b0, w, a};
    pwdata_in <= {24'h000000, d};
    @(posedge mclk_in);
    penable_in <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk_in);
      k++;
    end
    while (pready_out !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_errors++;
      report_and_stop();
    end
    {rd, er} = {prdata_out, pslverr_out};
    {psel_in, penable_in} <= 2'b00;
  endtask : apb
  function automatic logic [7:0] man(input logic [3:0] n);
    logic [7:0] r;
    for (int i = 0; i < 4; i++)
      r[2*i +: 2] = n[i] ? 2'b01 : 2'b10;
    return r;
  endfunction : man
  function automatic logic [23:0] s36(input logic [15:0] d);
    return {sym[d[15:12]], sym[d[11:8]], sym[d[7:4]], sym[d[3:0]]};
  endfunction : s36
  task automatic op(input logic [7:0] v, input logic [23:0] di, input logic [23:0] x,
    input logic e);
    int k;
    apb(1'b1, AC, 8'h00);
    apb(1'b1, AH, di[23:16]);
    apb(1'b1, AM, di[15:8]);
    apb(1'b1, AL, di[7:0]);
    apb(1'b1, AC, v);
    k = 0;
    do
    begin
      apb(1'b0, AC, 8'h00);
      k++;
    end
    while (rd[7] !== 1'b1 && k < 20);
    if (rd[7] !== 1'b1)
    begin
      n_errors++;
      report_and_stop();
    end
    chk("control", rd, {40'h0, 1'b1, e, 2'b00, v[3:0]});
    apb(1'b0, AH, 8'h00);
    chk("high", rd, x[23:16]);
    apb(1'b0, AM, 8'h00);
    chk("middle", rd, x[15:8]);
    apb(1'b0, AL, 8'h00);
    chk("low", rd, x[7:0]);
    chk("irq", err_irq_out, e);
  endtask : op
  task automatic t_regs;
    apb(1'b0, 12'h300, 8'h00);
    chk("unmapped", {rd, er}, 33'h1);
    apb(1'b0, AC | 12'h001, 8'h00);
    chk("unaligned", er, 1'b1);
    apb(1'b0, AC, 8'h00);
    chk("control reset", rd, 0);
  endtask : t_regs
  task automatic t_sticky;
    apb(1'b1, AC, 8'hC0);
    apb(1'b0, AC, 8'h00);
    chk("sticky", rd, 8'hC0);
    apb(1'b1, AC, 8'h00);
    apb(1'b1, AC, 8'hC0);
    apb(1'b0, AC, 8'h00);
    chk("cleared", {rd, err_irq_out}, 0);
  endtask : t_sticky
  task automatic t_dma(input logic [7:0] v, input logic [47:0] s, input logic [47:0] x,
    input logic [3:0] n, input logic e, input logic [3:0] d);
    int k;
    apb(1'b1, AC, 8'h00);
    {src, dly, go} <= {s, d, 1'b1};
    apb(1'b1, AC, v);
    k = 0;
    while (n_got !== n && k < 300)
    begin
      @(posedge mclk_in);
      k++;
    end
    if (n_got !== n)
    begin
      n_errors++;
      report_and_stop();
    end
    chk("stream", sink, x);
    // Stall both channels first so no further unit can move the flags
    go <= 1'b0;
    apb(1'b0, AC, 8'h00);
    chk("dma flags", rd[7:6], {1'b1, e});
    chk("dma irq", err_irq_out, e);
    apb(1'b1, AC, 8'h00);
  endtask : t_dma
  initial
  begin
    logic [15:0] d;
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_regs();
    op(8'h20, 24'h00005A, {8'h00, man(4'h5), man(4'hA)}, 1'b0);
    op(8'h10, {8'h00, man(4'hC), man(4'h3)}, 24'h0000C3, 1'b0);
    op(8'h10, 24'h005557, 24'h0000FF, 1'b1);
    t_sticky();
    for (int i = 0; i < 4; i++)
    begin
      d = {4'(4*i), 4'(4*i+1), 4'(4*i+2), 4'(4*i+3)};
      op(8'h21, {8'h00, d}, s36(d), 1'b0);
      op(8'h11, s36(d), {8'h00, d}, 1'b0);
    end
    op(8'h11, {sym[1], sym[2], sym[3], 6'h3F}, 24'h001230, 1'b1);
    t_dma(8'h16, 48'h55AA55570000, 48'hF0FF, 4'h2, 1'b1, 4'h0);
    t_dma(8'h26, 48'hA50000000000, {man(4'hA), man(4'h5)}, 4'h2, 1'b0, 4'h2);
    t_dma(8'h27, 48'h123400000000, s36(16'h1234), 4'h3, 1'b0, 4'h3);
    t_dma(8'h17, {s36(16'hBEEF), 24'h0}, 48'hBEEF, 4'h2, 1'b0, 4'h1);
    t_dma(8'h14, 48'hAA5500000000, 48'hF0, 4'h1, 1'b0, 4'h0);
    report_and_stop();
  end
endmodule : test_mc36_codec
